// file: core/pcscs_pkg.sv
// Constants and carrier types for the 100 Mb/s PCS configuration register bank.
// Assumes a 40 MHz device clock and an APB register bus with 32-bit data.
package pcscs_pkg;

  // Register map: printed offset 0x16 is not a word multiple, so it is an index
  localparam logic [7:0]  PCSCS_CFG_IDX      = 8'h16;
  localparam logic [11:0] PCSCS_CFG_ADDR     = 12'h058;   // Index times four
  localparam logic [11:0] PCSCS_LINK_ADDR    = 12'h05C;   // Index plus one: status word

  // Field positions inside the configuration word
  localparam int PCSCS_FREE_CLK_BIT  = 11;
  localparam int PCSCS_QUIET_BIT     = 10;
  localparam int PCSCS_FSD_BIT       = 9;
  localparam int PCSCS_SDPOL_BIT     = 8;
  localparam int PCSCS_DTIME_BIT     = 7;
  localparam int PCSCS_FIBER_BIT     = 6;
  localparam int PCSCS_FORCE_BIT     = 5;
  localparam int PCSCS_FEFI_BIT      = 3;
  localparam int PCSCS_NRZI_BIT      = 2;
  localparam int PCSCS_SCRBYP_BIT    = 1;
  localparam int PCSCS_DSCBYP_BIT    = 0;

  // Writable mask and reset value with the fiber strap low
  localparam logic [15:0] PCSCS_WR_MASK      = 16'h0FEF;
  localparam logic [15:0] PCSCS_RESET_VAL    = 16'h0100;
  localparam logic [15:0] PCSCS_STRAP_MASK   = 16'h004B;  // Fiber, fault, both bypasses

  // Descrambler loss-of-sync timeouts
  localparam int PCSCS_CLK_MHZ       = 40;
  localparam int PCSCS_TO_SHORT_US   = 722;
  localparam int PCSCS_TO_LONG_MS    = 2;
  localparam int PCSCS_TO_SHORT_CYC  = PCSCS_TO_SHORT_US * PCSCS_CLK_MHZ;
  localparam int PCSCS_TO_LONG_CYC   = PCSCS_TO_LONG_MS * 1000 * PCSCS_CLK_MHZ;

  // Control fields handed to the PCS datapath
  typedef struct packed {
    logic rx_clk_free;
    logic quiet_transmit_enable;
    logic force_signal_detect;
    logic signal_detect_policy;
    logic descrambler_timeout_select;
    logic fiber_mode_enable;
    logic force_good_link;
    logic far_end_fault_enable;
    logic nrzi_bypass;
    logic tx_scrambler_bypass;
    logic rx_descrambler_bypass;
  } pcscs_ctrl_t;

endpackage

// file: core/pcscs_link.sv
// Link qualifier: signal level, descrambler lock and loss-of-sync timeout.
// Assumes level and lock inputs are already synchronous to CLK.
`timescale 1ns/100ps
module pcscs_link
  import pcscs_pkg::*;
#(
  parameter int SHORT_CYC = PCSCS_TO_SHORT_CYC,
  parameter int LONG_CYC  = PCSCS_TO_LONG_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // Configuration
  input  wire logic keep_on_lock_loss,
  input  wire logic long_timeout,
  input  wire logic force_good,
  // Receive status
  input  wire logic level_ok,
  input  wire logic lock_ok,
  // Results
  output logic      link_up,
  output logic      sync_lost
);

  logic [16:0] idle_cnt_reg;
  logic [16:0] idle_cnt_next;
  logic [16:0] limit;
  logic        link_next;

  // Timeout limit from the select bit; the long one tolerates jumbo frames
  assign limit = long_timeout ? 17'(LONG_CYC - 1) : 17'(SHORT_CYC - 1);

  // Count cycles without lock; reaching the limit declares sync lost
  assign idle_cnt_next = lock_ok ? 17'h00000 :
                         (idle_cnt_reg >= limit) ? idle_cnt_reg : idle_cnt_reg + 17'h00001;

  // Link rises on level and lock, falls per policy; the force path overrides
  always_comb begin
    if (force_good)
      link_next = 1'b1;
    else if (!link_up)
      link_next = level_ok && lock_ok;
    else if (keep_on_lock_loss)
      link_next = level_ok;
    else
      link_next = level_ok && !sync_lost;
  end

  // State
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_reg <= 17'h00000;
      link_up      <= 1'b0;
      sync_lost    <= 1'b0;
    end else if (ce) begin
      idle_cnt_reg <= idle_cnt_next;
      link_up      <= link_next;
      sync_lost    <= !lock_ok && (idle_cnt_reg >= limit);
    end
  end

endmodule

// file: core/pcscs_regs.sv
// APB register bank for the 100 Mb/s PCS configuration and status word.
// Assumes an APB master on CLK; strap and force-link pins come from outside.
//
// How it works
// - Bit 11 set lets the receive clock run freely; resets to zero.
// - Bit 10 set puts the transmitter in true quiet mode; resets zero.
// - Bit 9 set forces signal detect in the attachment layer; resets zero.
// - Bit 8 one: link on level and lock, held while level stays valid.
// - Bit 8 zero: link drops on bad level or descrambler lock loss.
// - Bit 7 selects descrambler timeout: 2 ms when one, 722 us when zero.
// - Bit 6 enables fiber mode; reset value follows the fiber strap.
// - Good link is forced by bit 5 or the external force-link input.
// - Bit 4 is read-only zero; writes have no effect.
// - Bit 3 enables far end fault; reset value follows the fiber strap.
// - Bit 2 set bypasses NRZI coding; resets to zero.
// - Bit 1 set bypasses the transmit scrambler; strap sets its reset value.
// - Bit 0 set bypasses the receive descrambler; strap sets its reset value.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module pcscs_regs
  import pcscs_pkg::*;
#(
  parameter int SHORT_CYC = PCSCS_TO_SHORT_CYC,
  parameter int LONG_CYC  = PCSCS_TO_LONG_CYC
) (
  // Clock, reset and enable
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Pins from outside the clock domain
  input  wire logic        FIBER_STRAP,
  input  wire logic        EXTERNAL_FORCE_LINK_INPUT,
  input  wire logic        SIGNAL_LEVEL_OK,
  input  wire logic        DESCRAMBLER_LOCKED,
  // Controls to the PCS datapath
  output pcscs_ctrl_t      CTRL,
  output logic             LINK_UP,
  output logic             SYNC_LOST
);

  // Synchronisers: first stage read only by the second
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else if (CE) begin
      pin_s1_reg <= {FIBER_STRAP, EXTERNAL_FORCE_LINK_INPUT, SIGNAL_LEVEL_OK, DESCRAMBLER_LOCKED};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire strap_s   = pin_s2_reg[3];
  wire force_s   = pin_s2_reg[2];
  wire level_s   = pin_s2_reg[1];
  wire lock_s    = pin_s2_reg[0];

  // Strap is caught once after reset release, not under the async reset
  logic        strap_done_reg;
  logic [1:0]  settle_reg;
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;

  // APB decode: zero-wait slave, answer in the access phase
  wire access     = PSEL && PENABLE;
  wire hit_cfg    = PADDR == PCSCS_CFG_ADDR;
  wire hit_link   = PADDR == PCSCS_LINK_ADDR;
  wire wr_cfg     = access && PWRITE && hit_cfg;

  // Strap-derived reset pattern for fiber, fault and both bypasses
  wire [15:0] strap_val = PCSCS_RESET_VAL | (strap_s ? PCSCS_STRAP_MASK : 16'h0000);

  // Whole-word update of writable bits; bit 4 masked to zero
  assign cfg_next = PWDATA[15:0] & PCSCS_WR_MASK;

  // Configuration register; software write wins over the late strap load
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_reg        <= PCSCS_RESET_VAL;
      strap_done_reg <= 1'b0;
      settle_reg     <= 2'h0;
    end else if (CE) begin
      if (wr_cfg) begin
        cfg_reg        <= cfg_next;
        strap_done_reg <= 1'b1;
      end else if (!strap_done_reg && settle_reg == 2'h2) begin
        cfg_reg        <= strap_val;
        strap_done_reg <= 1'b1;
      end
      if (settle_reg != 2'h2)
        settle_reg <= settle_reg + 2'h1;                       // Wait for synchroniser fill
    end
  end

  // Link qualifier driven by the policy and timeout bits
  logic link_up_w;
  logic sync_lost_w;
  pcscs_link #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_link (
    .clk               (CLK),
    .rst_b             (RST_B),
    .ce                (CE),
    .keep_on_lock_loss (cfg_reg[PCSCS_SDPOL_BIT]),
    .long_timeout      (cfg_reg[PCSCS_DTIME_BIT]),
    .force_good        (cfg_reg[PCSCS_FORCE_BIT] | force_s),
    .level_ok          (level_s | cfg_reg[PCSCS_FSD_BIT]),
    .lock_ok           (lock_s | cfg_reg[PCSCS_DSCBYP_BIT]),
    .link_up           (link_up_w),
    .sync_lost         (sync_lost_w)
  );

  // Read mux: config word or link status word
  wire [31:0] rd_val = hit_cfg  ? {16'h0000, cfg_reg} :
                       hit_link ? {30'h0, sync_lost_w, link_up_w} : 32'h00000000;

  // Outputs registered; PREADY high in every access phase
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA    <= 32'h00000000;
      PREADY    <= 1'b0;
      PSLVERR   <= 1'b0;
      CTRL      <= '0;
      LINK_UP   <= 1'b0;
      SYNC_LOST <= 1'b0;
    end else if (CE) begin
      PREADY    <= PSEL && !PENABLE;
      PSLVERR   <= 1'b0;
      if (PSEL && !PENABLE) begin
        PRDATA  <= PWRITE ? 32'h00000000 : rd_val;
        PSLVERR <= !(hit_cfg || (hit_link && !PWRITE));
      end
      CTRL.rx_clk_free                <= cfg_reg[PCSCS_FREE_CLK_BIT];
      CTRL.quiet_transmit_enable      <= cfg_reg[PCSCS_QUIET_BIT];
      CTRL.force_signal_detect        <= cfg_reg[PCSCS_FSD_BIT];
      CTRL.signal_detect_policy       <= cfg_reg[PCSCS_SDPOL_BIT];
      CTRL.descrambler_timeout_select <= cfg_reg[PCSCS_DTIME_BIT];
      CTRL.fiber_mode_enable          <= cfg_reg[PCSCS_FIBER_BIT];
      CTRL.force_good_link            <= cfg_reg[PCSCS_FORCE_BIT] | force_s;
      CTRL.far_end_fault_enable       <= cfg_reg[PCSCS_FEFI_BIT];
      CTRL.nrzi_bypass                <= cfg_reg[PCSCS_NRZI_BIT];
      CTRL.tx_scrambler_bypass        <= cfg_reg[PCSCS_SCRBYP_BIT];
      CTRL.rx_descrambler_bypass      <= cfg_reg[PCSCS_DSCBYP_BIT];
      LINK_UP   <= link_up_w;
      SYNC_LOST <= sync_lost_w;
    end
  end

endmodule

// file: verif/pcscs_far.sv
// Receive-side partner: drives signal level and descrambler lock pins.
// Assumes the bench picks the line state; pins change after a rising edge.
`timescale 1ns/100ps
module pcscs_far (
  // Clock and request
  input  wire logic       clk,
  input  wire logic [1:0] cmd,
  // Line state pins
  output logic            level_ok,
  output logic            locked
);
  // Registered so pins never move in the sampling step of the block
  always_ff @(posedge clk) begin
    {level_ok, locked} <= cmd;
  end
endmodule

// file: verif/pcscs_regs_asserts.sv
// Checker on the register bank ports: APB answers, control fields, link.
// Assumes CE is held high by the bench, so every edge counts.
`timescale 1ns/100ps
module pcscs_regs_asserts
  import pcscs_pkg::*;
(
  // Watched ports
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        EXTERNAL_FORCE_LINK_INPUT,
  input wire logic        SIGNAL_LEVEL_OK,
  input wire pcscs_ctrl_t CTRL,
  input wire logic        LINK_UP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Setup of a config write; commit at the access edge, CTRL seen three edges on
  wire wr = PSEL && !PENABLE && PWRITE && PADDR == PCSCS_CFG_ADDR;
  wire rd = PREADY && !PWRITE && PADDR == PCSCS_CFG_ADDR;
  wire bad = PADDR != PCSCS_CFG_ADDR && PADDR != PCSCS_LINK_ADDR;
  chk_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no answer after setup");
  chk_resv_zero: assert property (rd |-> PRDATA[31:12] == 0 && !PRDATA[4])
    else $error("reserved bits read nonzero");
  chk_bad_addr: assert property (PREADY && bad |-> PSLVERR)
    else $error("unmapped access not refused");
  chk_clk_quiet: assert property (wr |-> ##3
    {CTRL.rx_clk_free, CTRL.quiet_transmit_enable} == $past(PWDATA[11:10], 3))
    else $error("clock or quiet field wrong");
  chk_sd_force: assert property (wr |-> ##3
    CTRL.force_signal_detect == $past(PWDATA[9], 3))
    else $error("signal force field wrong");
  chk_sd_policy: assert property (wr |-> ##3
    CTRL.signal_detect_policy == $past(PWDATA[8], 3))
    else $error("policy field wrong");
  chk_tmo_sel: assert property (wr |-> ##3
    CTRL.descrambler_timeout_select == $past(PWDATA[7], 3))
    else $error("timeout field wrong");
  chk_fiber_fefi: assert property (wr |-> ##3 {CTRL.fiber_mode_enable,
    CTRL.far_end_fault_enable} == {$past(PWDATA[6], 3), $past(PWDATA[3], 3)})
    else $error("fiber or fault field wrong");
  chk_bypass: assert property (wr |-> ##3 {CTRL.nrzi_bypass,
    CTRL.tx_scrambler_bypass, CTRL.rx_descrambler_bypass} == $past(PWDATA[2:0], 3))
    else $error("bypass fields wrong");
  chk_force_up: assert property (EXTERNAL_FORCE_LINK_INPUT[*5] |-> LINK_UP)
    else $error("forced link not up");
  chk_level_down: assert property ((!SIGNAL_LEVEL_OK && !EXTERNAL_FORCE_LINK_INPUT
    && !CTRL.force_good_link && !CTRL.force_signal_detect)[*6] |-> !LINK_UP)
    else $error("link up without signal level");
endmodule
bind pcscs_regs pcscs_regs_asserts i_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EXTERNAL_FORCE_LINK_INPUT(EXTERNAL_FORCE_LINK_INPUT),
  .SIGNAL_LEVEL_OK(SIGNAL_LEVEL_OK), .CTRL(CTRL), .LINK_UP(LINK_UP));

// file: verif/pcs_100m_config_status_reg_tb.sv
// Bench for the PCS config register bank: APB master, strap and line pins.
// Assumes zero-wait APB answers and short timeout parameters.
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pcs_100m_config_status_reg_tb;
  import pcscs_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic        strap = 0, force_in = 0, pready, pslverr, level_ok, locked, err;
  logic [1:0]  cmd = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  pcscs_ctrl_t ctrl;
  logic        link_up, sync_lost;
  int          n_fail = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  pcscs_far i_far (.clk(clk), .cmd(cmd), .level_ok(level_ok), .locked(locked));
  pcscs_regs #(.SHORT_CYC(20), .LONG_CYC(50)) i_dut (.CLK(clk), .RST_B(rst_b),
    .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .FIBER_STRAP(strap), .EXTERNAL_FORCE_LINK_INPUT(force_in),
    .SIGNAL_LEVEL_OK(level_ok), .DESCRAMBLER_LOCKED(locked), .CTRL(ctrl),
    .LINK_UP(link_up), .SYNC_LOST(sync_lost));
  task stop_test;
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; request held until PREADY is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task reset_dut(input logic s);
    strap <= s; rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    repeat (6) @(posedge clk); // Strap load lands by edge 4
  endtask
  task t_strap;
    for (int s = 0; s < 2; s++) begin
      reset_dut(s[0]);
      apb(0, PCSCS_CFG_ADDR, 0);
      `CHK("reset cfg", s ? 32'h0000014B : 32'h00000100, rd)
      `CHK("reset ctrl", s ? 11'h0AB : 11'h080, ctrl)
      `CHK("cfg err", 1'b0, err)
    end
  endtask
  // Walk one bit through every field; upper reserved bits kept zero
  task t_bits;
    logic [31:0] v;
    for (int i = 0; i < 12; i++) begin
      v = 32'h1 << i;
      apb(1, PCSCS_CFG_ADDR, v); // Fiber change wants a host soft reset elsewhere
      apb(0, PCSCS_CFG_ADDR, 0);
      `CHK("cfg bit", v & 32'h00000FEF, rd)
      `CHK("ctrl bit", {v[11:5], v[3:0]}, ctrl)
    end
  endtask
  task t_err;
    apb(0, 12'h000, 0);
    `CHK("unmapped err", 1'b1, err)
    apb(1, PCSCS_LINK_ADDR, 32'h3);
    `CHK("status write err", 1'b1, err)
  endtask
  // Link policy: lock loss ignored with bit 8 set, fatal with it clear
  // Lock loss counts as lost only once the timeout (20 or 50 cycles here) runs out
  task line(input logic [1:0] c, input logic exp, input int cycles);
    cmd <= c;
    repeat (cycles) @(posedge clk);
    `CHK("link", exp, link_up)
  endtask
  task t_link;
    apb(1, PCSCS_CFG_ADDR, 32'h100);
    line(2'b11, 1, 8);
    apb(0, PCSCS_LINK_ADDR, 0);
    `CHK("status up", 32'h00000001, rd)
    line(2'b10, 1, 30);
    `CHK("sync lost", 1'b1, sync_lost)
    apb(1, PCSCS_CFG_ADDR, 32'h000);
    line(2'b11, 1, 8); line(2'b10, 1, 20); line(2'b10, 0, 10);
    apb(0, PCSCS_LINK_ADDR, 0);
    `CHK("status lost", 32'h00000002, rd)
    apb(1, PCSCS_CFG_ADDR, 32'h080);
    line(2'b11, 1, 8); line(2'b10, 1, 50); line(2'b10, 0, 10);
    line(2'b11, 1, 8); line(2'b01, 0, 8);
    apb(1, PCSCS_CFG_ADDR, 32'h200);
    line(2'b01, 1, 8);
    apb(1, PCSCS_CFG_ADDR, 32'h001);
    line(2'b10, 1, 30);
    force_in <= 1;
    line(2'b00, 1, 8);
    force_in <= 0;
    apb(1, PCSCS_CFG_ADDR, 32'h020);
    line(2'b00, 1, 8);
  endtask
  // Hang guard well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    t_strap;
    t_bits;
    t_err;
    t_link;
    stop_test;
  end
endmodule
